// ==== hw/pro_defs.svh ====
// register offsets, field positions, reset values and codes of the raster-op unit
// ==========================================================================
`ifndef PRO_DEFS_SVH
`define PRO_DEFS_SVH

// ==========================================================================
// register byte addresses
`define PRO_CTRL_ADDR 12'h000
`define PRO_STAT_ADDR 12'h004
`define PRO_PC_ADDR 12'h008
`define PRO_MASK_ADDR 12'h00C
`define PRO_PSZ_ADDR 12'h010
`define PRO_SRC_ADDR 12'h014
`define PRO_DST_ADDR 12'h018
`define PRO_RES_ADDR 12'h01C
`define PRO_CMD_ADDR 12'h020

// ==========================================================================
// field positions
`define PRO_OP_LSB 10
`define PRO_OP_MSB 14
`define PRO_XDIR_BIT 8
`define PRO_YDIR_BIT 9
`define PRO_RESUME_BIT 25
`define PRO_N_BIT 31
`define PRO_C_BIT 30
`define PRO_Z_BIT 29
`define PRO_V_BIT 28
`define PRO_PC_ALIGN 4
`define PRO_CMD_INTR 0
`define PRO_CMD_INTERRUPT_RETURN 1
`define PRO_CMD_STEP 2

// ==========================================================================
// reset values
`define PRO_CTRL_RST 16'h0000
`define PRO_STAT_RST 32'h00000010
`define PRO_PC_RST 32'h00000000
`define PRO_MASK_RST 16'h0000
`define PRO_PSZ_RST 5'h10

`endif

// ==== hw/pro_pkg.sv ====
// types shared by the raster-op unit
package pro_pkg;

    typedef enum logic [4:0] {
        OP_COPY, OP_AND, OP_ANDND, OP_ZERO, OP_ORND, OP_XNOR, OP_NOTD,
        OP_NOR, OP_OR, OP_KEEP, OP_XOR, OP_NSAND, OP_ONES, OP_NSOR,
        OP_NAND, OP_NOTS, OP_ADD, OP_ADDS, OP_SUB, OP_SUBS, OP_MAX, OP_MIN
    } pro_op_t;

    typedef struct packed {
        logic n;
        logic c;
        logic z;
        logic v;
    } pro_flags_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
    } pro_xy_t;

endpackage : pro_pkg

// ==== hw/pro_unit.sv ====
// raster-op datapath with its control, status, mask and pixel-size registers
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pro_defs.svh"

module pro_unit
    import pro_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // blit stepping and state
    output pro_xy_t blit_pos,
    output logic blit_active
);

    // ======================================================================
    // registers
    logic [15:0] ctrl_ff;
    logic [31:0] stat_ff;
    logic [31:0] pc_ff;
    logic [15:0] mask_ff;
    logic [4:0] psz_ff;
    logic [15:0] src_ff;
    logic [15:0] dst_ff;
    logic [15:0] res_ff;
    logic [31:0] saved_pc_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic pready_ff;
    pro_xy_t pos_ff;
    logic active_ff;

    logic wr_en;
    logic rd_en;
    logic map_hit;
    logic [31:0] nxt_prdata;
    pro_op_t op;
    logic [15:0] wmask;
    logic [15:0] s;
    logic [15:0] d;
    logic [15:0] dst_in;
    logic [16:0] sum;
    logic [16:0] dif;
    logic [15:0] nxt_res;
    pro_flags_t nxt_flags;

    // answer one cycle after setup: access phase always sees pready high
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign rd_en = psel && !penable;
    assign op = pro_op_t'(ctrl_ff[`PRO_OP_MSB:`PRO_OP_LSB]);

    // ======================================================================
    // pixel width mask
    always_comb
    begin
        unique case (psz_ff)
            5'h01: wmask = 16'h0001;
            5'h02: wmask = 16'h0003;
            5'h04: wmask = 16'h000F;
            5'h08: wmask = 16'h00FF;
            default: wmask = 16'hFFFF;
        endcase
    end

    assign s = src_ff & wmask;
    // a destination write combines with the word being written, not the old
    assign dst_in = (wr_en && paddr == `PRO_DST_ADDR) ? pwdata[15:0] : dst_ff;
    assign d = dst_in & wmask;
    assign sum = {1'b0, d} + {1'b0, s};
    assign dif = {1'b0, d} - {1'b0, s};

    // ======================================================================
    // combining logic
    always_comb
    begin
        nxt_res = d;
        case (op)
            OP_COPY: nxt_res = s;
            OP_ZERO: nxt_res = 16'h0000;
            OP_ONES: nxt_res = 16'hFFFF;
            OP_AND: nxt_res = s & d;
            OP_ANDND: nxt_res = s & ~d;
            OP_NSAND: nxt_res = ~s & d;
            OP_ORND: nxt_res = s | ~d;
            OP_OR: nxt_res = s | d;
            OP_NSOR: nxt_res = ~s | d;
            OP_XNOR: nxt_res = ~(s ^ d);
            OP_NOR: nxt_res = ~(s | d);
            OP_XOR: nxt_res = s ^ d;
            OP_NOTD: nxt_res = ~d;
            OP_KEEP: nxt_res = d;
            OP_NAND: nxt_res = ~(s & d);
            OP_NOTS: nxt_res = ~s;
            OP_ADD: nxt_res = sum[15:0];
            OP_SUB: nxt_res = dif[15:0];
            OP_ADDS: nxt_res = ((sum[15:0] & ~wmask) != 16'h0000 || sum[16])
                ? 16'hFFFF : sum[15:0];
            OP_SUBS: nxt_res = dif[16] ? 16'h0000 : dif[15:0];
            OP_MAX: nxt_res = (s > d) ? s : d;
            OP_MIN: nxt_res = (s < d) ? s : d;
            default: nxt_res = d;
        endcase
        nxt_res = nxt_res & wmask;
        // unwritten bits of the pixel come from the destination word
        nxt_res = (nxt_res & ~mask_ff) | (dst_in & mask_ff);
        nxt_flags.n = nxt_res[15];
        nxt_flags.z = (nxt_res == 16'h0000);
        nxt_flags.c = (op == OP_SUB || op == OP_SUBS) ? dif[16] : sum[16];
        nxt_flags.v = 1'b0;
    end

    // ======================================================================
    // apb read path
    always_comb
    begin
        map_hit = 1'b1;
        nxt_prdata = 32'h00000000;
        unique case (paddr)
            `PRO_CTRL_ADDR: nxt_prdata = {16'h0000, ctrl_ff};
            `PRO_STAT_ADDR: nxt_prdata = stat_ff;
            `PRO_PC_ADDR: nxt_prdata = pc_ff;
            `PRO_MASK_ADDR: nxt_prdata = {16'h0000, mask_ff};
            `PRO_PSZ_ADDR: nxt_prdata = {27'h0000000, psz_ff};
            `PRO_SRC_ADDR: nxt_prdata = {16'h0000, src_ff};
            `PRO_DST_ADDR: nxt_prdata = {16'h0000, dst_ff};
            `PRO_RES_ADDR: nxt_prdata = {16'h0000, res_ff};
            `PRO_CMD_ADDR: nxt_prdata = {31'h00000000, active_ff};
            default: map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= rd_en;
            if (rd_en)
            begin
                prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
                pslverr_ff <= !map_hit;
            end
        end
    end

    // ======================================================================
    // control, mask, operands
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_ff <= `PRO_CTRL_RST;
            mask_ff <= `PRO_MASK_RST;
            psz_ff <= `PRO_PSZ_RST;
            src_ff <= 16'h0000;
            dst_ff <= 16'h0000;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `PRO_CTRL_ADDR: ctrl_ff <= pwdata[15:0];
                `PRO_MASK_ADDR: mask_ff <= pwdata[15:0];
                `PRO_PSZ_ADDR:
                begin
                    // any other width is refused and the old one kept
                    if (pwdata == 32'h1 || pwdata == 32'h2 || pwdata == 32'h4
                        || pwdata == 32'h8 || pwdata == 32'h10)
                        psz_ff <= pwdata[4:0];
                end
                `PRO_SRC_ADDR: src_ff <= pwdata[15:0];
                `PRO_DST_ADDR: dst_ff <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // result and status, program counter
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            res_ff <= 16'h0000;
            stat_ff <= `PRO_STAT_RST;
        end
        else if (wr_en && paddr == `PRO_STAT_ADDR)
            stat_ff <= pwdata;
        else if (wr_en && paddr == `PRO_DST_ADDR)
        begin
            res_ff <= nxt_res;
        end
        else if (wr_en && paddr == `PRO_SRC_ADDR)
            res_ff <= res_ff;
        else if (wr_en && paddr == `PRO_RES_ADDR)
        begin
            res_ff <= nxt_res;
            stat_ff[`PRO_N_BIT:`PRO_V_BIT] <= nxt_flags;
        end
        else if (wr_en && paddr == `PRO_CMD_ADDR && pwdata[`PRO_CMD_INTR])
            stat_ff[`PRO_RESUME_BIT] <= active_ff;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pc_ff <= `PRO_PC_RST;
            saved_pc_ff <= `PRO_PC_RST;
        end
        else if (wr_en && paddr == `PRO_PC_ADDR)
            pc_ff <= {pwdata[31:`PRO_PC_ALIGN], 4'h0};
        else if (wr_en && paddr == `PRO_CMD_ADDR && pwdata[`PRO_CMD_INTR])
            saved_pc_ff <= pc_ff;
        else if (wr_en && paddr == `PRO_CMD_ADDR && pwdata[`PRO_CMD_INTERRUPT_RETURN])
            pc_ff <= {saved_pc_ff[31:`PRO_PC_ALIGN], 4'h0};
    end

    // ======================================================================
    // blit stepping: interrupt suspends, return resumes if flag set
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pos_ff <= '0;
            active_ff <= 1'b0;
        end
        else if (wr_en && paddr == `PRO_CMD_ADDR)
        begin
            if (pwdata[`PRO_CMD_INTR])
                active_ff <= 1'b0;
            else if (pwdata[`PRO_CMD_INTERRUPT_RETURN])
                active_ff <= stat_ff[`PRO_RESUME_BIT];
            else if (pwdata[`PRO_CMD_STEP])
            begin
                active_ff <= 1'b1;
                pos_ff.x <= ctrl_ff[`PRO_XDIR_BIT] ? pos_ff.x - 16'h0001
                    : pos_ff.x + 16'h0001;
                pos_ff.y <= ctrl_ff[`PRO_YDIR_BIT] ? pos_ff.y - 16'h0001
                    : pos_ff.y + 16'h0001;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign blit_pos = pos_ff;
    assign blit_active = active_ff;

endmodule : pro_unit

// ==== sim/pro_unit_chk.sv ====
// port assertions for the raster-op unit
`timescale 1ns/1ps
`include "pro_defs.svh"
module pro_unit_chk
    import pro_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // blit
    input wire pro_xy_t blit_pos,
    input wire logic blit_active
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ==================================================================
    // bus answer
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_err; psel && !penable && paddr > `PRO_CMD_ADDR
        |=> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("unmapped accepted");
    property p_ok; psel && !penable && paddr <= `PRO_CMD_ADDR
        && paddr[1:0] == 2'h0 |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped refused");
    // ==================================================================
    // register contents
    property p_pc; pready && !pwrite && paddr == `PRO_PC_ADDR
        |-> prdata[3:0] == 4'h0; endproperty
    a_pc: assert property (p_pc) else $error("pc unaligned");
    property p_psz; pready && !pwrite && paddr == `PRO_PSZ_ADDR
        |-> prdata inside {1, 2, 4, 8, 16}; endproperty
    a_psz: assert property (p_psz) else $error("bad width");
    property p_step; pready && pwrite && paddr == `PRO_CMD_ADDR
        && pwdata[2:0] == 3'h4 |=> blit_active; endproperty
    a_step: assert property (p_step) else $error("no step");
    property p_rst; $fell(srst) |-> !pready && !blit_active
        && blit_pos == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("not reset");
    c_err: cover property (pslverr);
    c_blit: cover property (blit_active);
    c_wr: cover property (pready && pwrite);
endmodule : pro_unit_chk

bind pro_unit pro_unit_chk pro_unit_chk_inst (.clock, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .blit_pos, .blit_active);

// ==== sim/pro_tb.sv ====
// self-checking bench for the raster-op unit
`timescale 1ns/1ps
`include "pro_defs.svh"
module testbench
    import pro_pkg::*;
;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pro_xy_t blit_pos;
    logic blit_active;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] rdv;
    logic last_err;

    pro_unit pro_unit_inst (.clock, .srst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .blit_pos,
        .blit_active);

    initial
    forever #50 clock = ~clock;

    // ==================================================================
    // helpers
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // one transfer; waits for ready on a bound, never a fixed count
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        rdv = prdata;
        last_err = pslverr;
        if (pready !== 1'h1)
            error_cnt++;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rdc(string n, logic [11:0] a, logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, rdv, e);
    endtask : rdc

    // width 8 reference: operands never exceed 8'hFF here
    function automatic logic [31:0] rop(int op, logic [31:0] s, d);
        logic [31:0] r;
        case (op)
            0: r = s;
            1: r = s & d;
            2: r = s & ~d;
            3: r = 32'h0;
            4: r = s | ~d;
            5: r = ~(s ^ d);
            6: r = ~d;
            7: r = ~(s | d);
            8: r = s | d;
            9: r = d;
            10: r = s ^ d;
            11: r = ~s & d;
            12: r = 32'hFF;
            13: r = ~s | d;
            14: r = ~(s & d);
            15: r = ~s;
            16: r = d + s;
            17: r = (d + s > 32'hFF) ? 32'hFF : d + s;
            18: r = d - s;
            19: r = (s > d) ? 32'h0 : d - s;
            20: r = (s > d) ? s : d;
            default: r = (s < d) ? s : d;
        endcase
        return r & 32'hFF;
    endfunction : rop

    // ==================================================================
    // scenarios
    task automatic t_reset();
        rdc("ctrl", `PRO_CTRL_ADDR, {16'h0, `PRO_CTRL_RST});
        rdc("stat", `PRO_STAT_ADDR, `PRO_STAT_RST);
        rdc("pc", `PRO_PC_ADDR, `PRO_PC_RST);
        rdc("mask", `PRO_MASK_ADDR, {16'h0, `PRO_MASK_RST});
        rdc("psz", `PRO_PSZ_ADDR, {27'h0, `PRO_PSZ_RST});
        chk("pos", blit_pos, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ops();
        logic [31:0] s;
        logic [31:0] d;
        apb(1'h1, `PRO_PSZ_ADDR, 32'h8);
        for (int op = 0; op < 22; op++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                s = p ? 32'hF0 : 32'hA5;
                d = p ? 32'h30 : 32'h3C;
                apb(1'h1, `PRO_CTRL_ADDR, 32'(op) << `PRO_OP_LSB);
                apb(1'h1, `PRO_SRC_ADDR, s);
                apb(1'h1, `PRO_DST_ADDR, d);
                rdc("result", `PRO_RES_ADDR, rop(op, s, d));
            end
        end
        $display("test ops done");
    endtask : t_ops

    task automatic t_regs();
        apb(1'h1, `PRO_CTRL_ADDR, 32'h0C00);
        apb(1'h1, `PRO_RES_ADDR, 32'h0);
        rdc("flags", `PRO_STAT_ADDR, 32'h20000010);
        apb(1'h1, `PRO_PC_ADDR, 32'h4302);
        rdc("pc", `PRO_PC_ADDR, 32'h4300);
        apb(1'h1, `PRO_PSZ_ADDR, 32'h3);
        rdc("psz", `PRO_PSZ_ADDR, 32'h8);
        apb(1'h1, `PRO_CTRL_ADDR, 32'h3300);
        rdc("ctrl", `PRO_CTRL_ADDR, 32'h3300);
        apb(1'h1, `PRO_MASK_ADDR, 32'hF0);
        apb(1'h1, `PRO_DST_ADDR, 32'h3C);
        rdc("masked", `PRO_RES_ADDR, 32'h3F);
        apb(1'h1, `PRO_MASK_ADDR, 32'h0);
        apb(1'h0, 12'h100, 32'h0);
        chk("slverr", last_err, 32'h1);
        chk("unmapped", rdv, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_blit();
        apb(1'h1, `PRO_CTRL_ADDR, 32'h0);
        apb(1'h1, `PRO_CMD_ADDR, 32'h4);
        @(negedge clock);
        chk("pos up", blit_pos, 32'h00010001);
        apb(1'h1, `PRO_CTRL_ADDR, 32'h0300);
        apb(1'h1, `PRO_CMD_ADDR, 32'h4);
        @(negedge clock);
        chk("pos down", blit_pos, 32'h0);
        apb(1'h1, `PRO_CMD_ADDR, 32'h1);
        apb(1'h0, `PRO_STAT_ADDR, 32'h0);
        chk("flag", rdv[25], 32'h1);
        apb(1'h1, `PRO_CMD_ADDR, 32'h2);
        @(negedge clock);
        chk("resumed", blit_active, 32'h1);
        apb(1'h1, `PRO_CMD_ADDR, 32'h1);
        apb(1'h1, `PRO_STAT_ADDR, 32'h10);
        apb(1'h1, `PRO_CMD_ADDR, 32'h2);
        @(negedge clock);
        chk("held", blit_active, 32'h0);
        $display("test blit done");
    endtask : t_blit

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        t_reset();
        t_ops();
        t_regs();
        t_blit();
        end_of_test();
    end

    // about 630 cycles expected; cut off far beyond that
    initial
    begin
        #2000000;
        error_cnt++;
        end_of_test();
    end
endmodule : testbench
